// ===== shared/tma_pkg.sv
// constants, register map and state layout of the 16-bit timer core
package tma_pkg;

    // --------------------
    // widths
    // --------------------
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 5;
    localparam int CHANNELS = 3;
    localparam int PRESC_W  = 10;

    // --------------------
    // register offsets
    // --------------------
    localparam logic [4:0] ADDR_CONTROL_A     = 5'h00;
    localparam logic [4:0] ADDR_CONTROL_B     = 5'h01;
    localparam logic [4:0] ADDR_CONTROL_E     = 5'h02;
    localparam logic [4:0] ADDR_CONTROL_F     = 5'h03;
    localparam logic [4:0] ADDR_EVENT_CONFIG  = 5'h04;
    localparam logic [4:0] ADDR_MATCH_FLAGS   = 5'h05;
    localparam logic [4:0] ADDR_MATCH_IRQ_EN  = 5'h06;
    localparam logic [4:0] ADDR_COUNTER       = 5'h08;
    localparam logic [4:0] ADDR_CYCLE_LENGTH  = 5'h09;
    localparam logic [4:0] ADDR_CYCLE_SHADOW  = 5'h0a;
    localparam logic [4:0] ADDR_MATCH_BASE    = 5'h0c;
    localparam logic [4:0] ADDR_MATCH_SH_BASE = 5'h10;

    // --------------------
    // field positions
    // --------------------
    localparam int CONTROL_REG_A_ENABLE_BIT   = 0;
    localparam int CONTROL_REG_A_TICK_SEL_LSB = 1;
    localparam int CONTROL_REG_B_WAVE_SEL_LSB = 0;
    localparam int CONTROL_REG_B_OUT_EN_LSB   = 4;
    localparam int CONTROL_REG_E_DIR_BIT      = 0;
    localparam int CONTROL_REG_F_CYCLE_BV_BIT = 0;
    localparam int CONTROL_REG_F_MATCH_BV_LSB = 1;
    localparam int EVCFG_TICK_EN_BIT  = 0;

    // --------------------
    // waveform modes
    // --------------------
    localparam logic [2:0] WAVE_NORMAL = 3'h0;
    localparam logic [2:0] WAVE_FREQ   = 3'h1;
    localparam logic [2:0] WAVE_SINGLE = 3'h3;
    localparam logic [2:0] WAVE_DUAL   = 3'h5;

    // prescaler terminal counts for ratios 1,2,4,8,16,64,256,1024
    localparam logic [PRESC_W-1:0] PRESC_LAST [8] = '{
        10'h000, 10'h001, 10'h003, 10'h007, 10'h00f, 10'h03f, 10'h0ff, 10'h3ff
    };

    // --------------------
    // reset values
    // --------------------
    localparam logic [DATA_W-1:0] RESET_CYCLE_LENGTH = 16'hffff;
    localparam logic [DATA_W-1:0] RESET_ZERO         = 16'h0000;

    // --------------------
    // carriers
    // --------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tma_bus_req_type;

    typedef struct packed {
        logic                             enable;
        logic [2:0]                       tick_source_select;
        logic [2:0]                       waveform_select;
        logic [CHANNELS-1:0]              match_output_enable;
        logic                             dir_down;
        logic                             event_tick_enable;
        logic [CHANNELS-1:0]              match_flag;
        logic [CHANNELS-1:0]              match_irq_enable;
        logic [DATA_W-1:0]                counter_value;
        logic [DATA_W-1:0]                cycle_length;
        logic [DATA_W-1:0]                cycle_length_shadow;
        logic                             cycle_shadow_valid;
        logic [CHANNELS-1:0][DATA_W-1:0]  match_value;
        logic [CHANNELS-1:0][DATA_W-1:0]  match_value_shadow;
        logic [CHANNELS-1:0]              match_shadow_valid;
        logic [PRESC_W-1:0]               presc;
        logic [2:0]                       ev_sync;
        logic                             ev_level;
        logic [CHANNELS-1:0]              wave;
        logic [CHANNELS-1:0]              pin;
        logic [CHANNELS-1:0]              irq;
        logic [DATA_W-1:0]                rdata;
    } tma_state_type;

endpackage

// ===== rtl/tma_core.sv
// 16-bit timer/counter core with three compare channels and waveform outputs
//
// Summary of operation
// - floor is zero, max is all ones
// - reload point at floor or ceiling per mode
// - ticks from clock, undivided or prescaled
// - event tick enable counts event edges
// - direction bit honoured, changeable while running
// - counting up, ceiling wraps to zero
// - counting down, zero reloads cycle length
// - counter write wins over counting
// - shadows with valid flags, committed at reload
// - active and shadow match values both writable
// - direct cycle length write acts immediately
// - low new ceiling runs to max, wraps
// - cycle shadow committed only at reload point
// - equality on a tick sets channel flag next cycle
// - match shadow committed only at reload point
// - waveform overrides pin under three conditions
// - frequency mode: match sets period, toggles
// - frequency zero match toggles every tick
// - single slope: high at ceiling, low match
// - ceiling sets resolution, three up to max
// - dual slope: up/down, set floor, match edges
// - dual slope period is twice ceiling
`timescale 1ns/1ps
`default_nettype none

module tma_core
    import tma_pkg::*;
(
    input  wire logic            clock,           // 100 MHz module clock
    input  wire logic            rst_n,           // asynchronous reset, active low
    input  wire tma_bus_req_type bus,             // register request
    output var  logic [DATA_W-1:0]   rdata,       // read data, cycle after read strobe
    input  wire logic            event_in,        // event input from outside domain
    input  wire logic [CHANNELS-1:0] port_out_value, // port output register value
    output var  logic [CHANNELS-1:0] pin_out,     // port pin level after override
    output var  logic [CHANNELS-1:0] match_irq    // per-channel interrupt request
);

    // --------------------
    // state
    // --------------------
    tma_state_type s;
    tma_state_type next_s;

    logic                 clk_tick;
    logic                 ev_edge;
    logic                 tick;
    logic                 update;
    logic                 wave_active;
    logic                 cnt_wr;
    logic [DATA_W-1:0]    top;
    logic [CHANNELS-1:0]  hit;
    logic [CHANNELS-1:0]  flag_clear;

    // --------------------
    // next state
    // --------------------
    always_comb begin
        next_s     = s;
        update     = 1'b0;
        flag_clear = '0;
        cnt_wr     = 1'b0;

        // event input: three stages, change taken when last two agree
        next_s.ev_sync = {s.ev_sync[1:0], event_in};
        if (s.ev_sync[1] == s.ev_sync[2]) begin
            next_s.ev_level = s.ev_sync[2];
        end
        ev_edge = (s.ev_sync[1] == s.ev_sync[2]) && s.ev_sync[2] && !s.ev_level;

        // prescaler runs only while enabled
        clk_tick = s.enable && (s.presc == PRESC_LAST[s.tick_source_select]);
        if (!s.enable || clk_tick) begin
            next_s.presc = '0;
        end else begin
            next_s.presc = s.presc + 10'h001;
        end

        tick = s.enable && (s.event_tick_enable ? ev_edge : clk_tick);

        // frequency mode takes its period from channel 0
        top = (s.waveform_select == WAVE_FREQ) ? s.match_value[0] : s.cycle_length;

        for (int i = 0; i < CHANNELS; i++) begin
            hit[i] = (s.counter_value == s.match_value[i]);
        end

        // write-one-to-clear of match flags, applied before the sets
        if (bus.wr && bus.addr == ADDR_MATCH_FLAGS) begin
            flag_clear = bus.wdata[CHANNELS-1:0];
        end
        next_s.match_flag = s.match_flag & ~flag_clear;

        // --------------------
        // counting
        // --------------------
        if (tick) begin
            if (s.waveform_select == WAVE_DUAL) begin
                if (!s.dir_down) begin
                    if (s.counter_value == top) begin
                        next_s.dir_down      = 1'b1;
                        next_s.counter_value = s.counter_value - 16'h0001;
                    end else begin
                        next_s.counter_value = s.counter_value + 16'h0001;
                    end
                end else begin
                    if (s.counter_value == RESET_ZERO) begin
                        next_s.dir_down      = 1'b0;
                        next_s.counter_value = 16'h0001;
                        update               = 1'b1;
                    end else begin
                        next_s.counter_value = s.counter_value - 16'h0001;
                    end
                end
            end else if (!s.dir_down) begin
                if (s.counter_value == top) begin
                    next_s.counter_value = RESET_ZERO;
                    update               = 1'b1;
                end else begin
                    // a ceiling below the count runs on to all ones and wraps
                    next_s.counter_value = s.counter_value + 16'h0001;
                end
            end else begin
                if (s.counter_value == RESET_ZERO) begin
                    next_s.counter_value = s.cycle_length;
                    update               = 1'b1;
                end else begin
                    next_s.counter_value = s.counter_value - 16'h0001;
                end
            end

            // --------------------
            // compare channels and waveforms
            // --------------------
            for (int i = 0; i < CHANNELS; i++) begin
                if (hit[i]) begin
                    next_s.match_flag[i] = 1'b1;
                end
                case (s.waveform_select)
                    WAVE_FREQ: begin
                        if (hit[i]) begin
                            next_s.wave[i] = ~s.wave[i];
                        end
                    end
                    WAVE_SINGLE: begin
                        if (s.counter_value == top) begin
                            next_s.wave[i] = 1'b1;
                        end else if (hit[i]) begin
                            next_s.wave[i] = 1'b0;
                        end
                    end
                    WAVE_DUAL: begin
                        if (s.counter_value == RESET_ZERO) begin
                            next_s.wave[i] = 1'b1;
                        end else if (hit[i]) begin
                            next_s.wave[i] = s.dir_down;
                        end
                    end
                    default: begin
                        next_s.wave[i] = 1'b0;
                    end
                endcase
            end
        end

        // --------------------
        // shadow commit at the reload point
        // --------------------
        if (update) begin
            if (s.cycle_shadow_valid) begin
                next_s.cycle_length       = s.cycle_length_shadow;
                next_s.cycle_shadow_valid = 1'b0;
            end
            for (int i = 0; i < CHANNELS; i++) begin
                if (s.match_shadow_valid[i]) begin
                    next_s.match_value[i]        = s.match_value_shadow[i];
                    next_s.match_shadow_valid[i] = 1'b0;
                end
            end
        end

        // --------------------
        // register writes, after counting so they take precedence
        // --------------------
        if (bus.wr) begin
            case (bus.addr)
                ADDR_CONTROL_A: begin
                    next_s.enable             = bus.wdata[CONTROL_REG_A_ENABLE_BIT];
                    next_s.tick_source_select = bus.wdata[CONTROL_REG_A_TICK_SEL_LSB +: 3];
                end
                ADDR_CONTROL_B: begin
                    next_s.waveform_select     = bus.wdata[CONTROL_REG_B_WAVE_SEL_LSB +: 3];
                    next_s.match_output_enable = bus.wdata[CONTROL_REG_B_OUT_EN_LSB +: CHANNELS];
                end
                ADDR_CONTROL_E: begin
                    next_s.dir_down = bus.wdata[CONTROL_REG_E_DIR_BIT];
                end
                ADDR_EVENT_CONFIG: begin
                    next_s.event_tick_enable = bus.wdata[EVCFG_TICK_EN_BIT];
                end
                ADDR_MATCH_IRQ_EN: begin
                    next_s.match_irq_enable = bus.wdata[CHANNELS-1:0];
                end
                ADDR_COUNTER: begin
                    cnt_wr               = 1'b1;
                    next_s.counter_value = bus.wdata;
                end
                ADDR_CYCLE_LENGTH: begin
                    next_s.cycle_length = bus.wdata;
                end
                ADDR_CYCLE_SHADOW: begin
                    next_s.cycle_length_shadow = bus.wdata;
                    next_s.cycle_shadow_valid  = 1'b1;
                end
                default: begin
                end
            endcase
            for (int i = 0; i < CHANNELS; i++) begin
                if (bus.addr == ADDR_MATCH_BASE + 5'(i)) begin
                    next_s.match_value[i] = bus.wdata;
                end
                if (bus.addr == ADDR_MATCH_SH_BASE + 5'(i)) begin
                    next_s.match_value_shadow[i] = bus.wdata;
                    next_s.match_shadow_valid[i] = 1'b1;
                end
            end
        end

        // --------------------
        // register reads, data stand one cycle after the strobe
        // --------------------
        next_s.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CONTROL_A: begin
                    next_s.rdata[CONTROL_REG_A_ENABLE_BIT]        = s.enable;
                    next_s.rdata[CONTROL_REG_A_TICK_SEL_LSB +: 3] = s.tick_source_select;
                end
                ADDR_CONTROL_B: begin
                    next_s.rdata[CONTROL_REG_B_WAVE_SEL_LSB +: 3]      = s.waveform_select;
                    next_s.rdata[CONTROL_REG_B_OUT_EN_LSB +: CHANNELS] = s.match_output_enable;
                end
                ADDR_CONTROL_E: begin
                    next_s.rdata[CONTROL_REG_E_DIR_BIT] = s.dir_down;
                end
                ADDR_CONTROL_F: begin
                    next_s.rdata[CONTROL_REG_F_CYCLE_BV_BIT]              = s.cycle_shadow_valid;
                    next_s.rdata[CONTROL_REG_F_MATCH_BV_LSB +: CHANNELS] = s.match_shadow_valid;
                end
                ADDR_EVENT_CONFIG: begin
                    next_s.rdata[EVCFG_TICK_EN_BIT] = s.event_tick_enable;
                end
                ADDR_MATCH_FLAGS: begin
                    next_s.rdata[CHANNELS-1:0] = s.match_flag;
                end
                ADDR_MATCH_IRQ_EN: begin
                    next_s.rdata[CHANNELS-1:0] = s.match_irq_enable;
                end
                ADDR_COUNTER: begin
                    next_s.rdata = s.counter_value;
                end
                ADDR_CYCLE_LENGTH: begin
                    next_s.rdata = s.cycle_length;
                end
                ADDR_CYCLE_SHADOW: begin
                    next_s.rdata = s.cycle_length_shadow;
                end
                default: begin
                end
            endcase
            for (int i = 0; i < CHANNELS; i++) begin
                if (bus.addr == ADDR_MATCH_BASE + 5'(i)) begin
                    next_s.rdata = s.match_value[i];
                end
                if (bus.addr == ADDR_MATCH_SH_BASE + 5'(i)) begin
                    next_s.rdata = s.match_value_shadow[i];
                end
            end
        end

        // --------------------
        // pin override and interrupt requests
        // --------------------
        wave_active = (next_s.waveform_select != WAVE_NORMAL) && !next_s.event_tick_enable;
        for (int i = 0; i < CHANNELS; i++) begin
            if (wave_active && next_s.match_output_enable[i]) begin
                next_s.pin[i] = next_s.wave[i];
            end else begin
                next_s.pin[i] = port_out_value[i];
            end
        end
        next_s.irq = next_s.match_flag & next_s.match_irq_enable;
    end

    // --------------------
    // registers
    // --------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s              <= '0;
            s.cycle_length <= RESET_CYCLE_LENGTH;
        end else begin
            s <= next_s;
        end
    end

    assign rdata     = s.rdata;
    assign pin_out   = s.pin;
    assign match_irq = s.irq;

endmodule

`default_nettype wire

// ===== dv/tma_core_properties.sv
// port assertions for the timer core
`timescale 1ns/1ps
`default_nettype none

module tma_core_properties
    import tma_pkg::*;
(
    input wire logic                clock,          // module clock
    input wire logic                rst_n,          // async reset, active low
    input wire tma_bus_req_type     bus,            // register request
    input wire logic [DATA_W-1:0]   rdata,          // read data
    input wire logic                event_in,       // event input
    input wire logic [CHANNELS-1:0] port_out_value, // port register value
    input wire logic [CHANNELS-1:0] pin_out,        // pin level
    input wire logic [CHANNELS-1:0] match_irq       // irq requests
);
    logic [2:0]          wsel;
    logic [CHANNELS-1:0] oen;
    logic [CHANNELS-1:0] ien;
    logic [CHANNELS-1:0] pass;
    logic                evt;
    logic                w1;
    logic                w2;
    logic                live;
    logic                rdm;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // --------------------
    // copies of configuration writes
    // --------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {wsel, oen, ien, evt, w1, w2, live} <= '0;
        end else begin
            if (bus.wr && bus.addr == ADDR_CONTROL_B) {oen, wsel} <= {bus.wdata[6:4], bus.wdata[2:0]};
            if (bus.wr && bus.addr == ADDR_EVENT_CONFIG) evt <= bus.wdata[0];
            if (bus.wr && bus.addr == ADDR_MATCH_IRQ_EN) ien <= bus.wdata[2:0];
            w1 <= bus.wr && (bus.addr == ADDR_MATCH_FLAGS || bus.addr == ADDR_MATCH_IRQ_EN);
            w2 <= w1;
            live <= 1'b1;
        end
    end
    assign pass = (wsel inside {WAVE_FREQ, WAVE_SINGLE, WAVE_DUAL} && !evt) ? ~oen : '1;
    assign rdm = bus.addr inside {5'h07, 5'h0b, 5'h0f} || bus.addr > 5'h12;

    // --------------------
    // assertions
    // --------------------
    AST_RDATA_IDLE: assert property (!bus.rd |=> rdata == '0)
        else $error("read data not zero outside answer");
    AST_UNMAPPED: assert property (bus.rd && rdm |=> rdata == '0)
        else $error("unmapped read not zero");
    AST_CONTROL_REG_F_RES: assert property (bus.rd && bus.addr == ADDR_CONTROL_F |=> rdata[15:4] == '0)
        else $error("control f reserved bits set");
    AST_CYCLE_NOW: assert property (bus.wr && bus.addr == ADDR_CYCLE_LENGTH ##1
        bus.rd && bus.addr == ADDR_CYCLE_LENGTH |=> rdata == $past(bus.wdata, 2))
        else $error("cycle length write not immediate");
    AST_MATCH_RW: assert property (bus.wr && bus.addr inside {[5'h0c:5'h0e], [5'h10:5'h12]} ##1
        bus.rd && $stable(bus.addr) |=> rdata == $past(bus.wdata, 2))
        else $error("match register write lost");
    AST_COUNT_WRITE: assert property (bus.wr && bus.addr == ADDR_COUNTER ##1
        bus.rd && bus.addr == ADDR_COUNTER |=> rdata == $past(bus.wdata, 2))
        else $error("counter write did not win");
    AST_IRQ_GATED: assert property ((match_irq & ~ien & ~$past(ien)) == '0)
        else $error("irq without enable");
    AST_IRQ_HOLD: assert property (|($past(match_irq) & ~match_irq) |-> w1 || w2)
        else $error("irq dropped without write");
    AST_PIN_PASS: assert property (live |-> ((pin_out ^ $past(port_out_value)) & pass) == '0)
        else $error("pin not port value");

    cover property (|match_irq);
    cover property (bus.wr && bus.addr == ADDR_CYCLE_SHADOW);
    cover property (pin_out[0] != $past(pin_out[0]) ##1 pin_out[0] != $past(pin_out[0]));
endmodule

bind tma_core tma_core_properties tma_core_properties_inst (.clock(clock), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .event_in(event_in), .port_out_value(port_out_value), .pin_out(pin_out),
    .match_irq(match_irq));

`default_nettype wire

// ===== dv/test_tma_core.sv
// self-checking bench for the timer core
`timescale 1ns/1ps
`default_nettype none

module test_tma_core
    import tma_pkg::*;
;
    logic                clock = 1'b0;
    logic                rst_n = 1'b0;
    tma_bus_req_type     bus = '0;
    logic [DATA_W-1:0]   rdata;
    logic                event_in = 1'b0;
    logic [CHANNELS-1:0] port_out_value = '0;
    logic [CHANNELS-1:0] pin_out;
    logic [CHANNELS-1:0] match_irq;
    int                  error_cnt = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    int                  t;
    logic [DATA_W-1:0]   v;
    logic [DATA_W-1:0]   d [8];
    logic [4:0]          ta [8] = '{5'h09, 5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h11, 5'h12, 5'h0a};

    always #5 clock = ~clock;

    tma_core tma_core_inst (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata), .event_in(event_in),
        .port_out_value(port_out_value), .pin_out(pin_out), .match_irq(match_irq));

    // --------------------
    // reporting
    // --------------------
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            error_cnt++;
            $display("FAIL %0t run too long", $time);
            results();
        end
    end

    // --------------------
    // register bus
    // --------------------
    task automatic wr(input logic [4:0] a, input logic [DATA_W-1:0] dat);
        @(posedge clock);
        bus <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [DATA_W-1:0] q);
        @(posedge clock);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '0;
        @(negedge clock);
        q = rdata;
    endtask

    task automatic wr_rd(input logic [4:0] a, input logic [DATA_W-1:0] dat);
        @(posedge clock);
        bus <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
        rd(a, v);
        chk(v, dat, "readback");
    endtask

    // --------------------
    // counter model: step value and tick spacing
    // --------------------
    task automatic burst(input int top, input bit down, input int n);
        logic [DATA_W-1:0] s [$];
        int prev;
        int run = 1;
        int first = 1;
        for (int i = 0; i < 10 * n + 2; i++) begin
            @(posedge clock);
            bus <= '{addr: ADDR_COUNTER, wdata: '0, wr: 1'b0, rd: 1'b1};
            @(negedge clock);
            if (i > 0) s.push_back(rdata);
        end
        @(posedge clock);
        bus <= '0;
        @(negedge clock);
        s.push_back(rdata);
        prev = s[0];
        for (int i = 1; i < s.size(); i++) begin
            if (s[i] === 16'(prev)) begin
                run++;
            end else begin
                chk(s[i], 16'(down ? (prev == 0 ? top : prev - 1) : (prev == top ? 0 : prev + 1)), "step");
                if (!first) chk(16'(run), 16'(n), "tick spacing");
                first = 0;
                run = 1;
                prev = s[i];
            end
        end
        chk(16'(first), 16'h0000, "counter moved");
    endtask

    // --------------------
    // waveform model: high time and edges
    // --------------------
    task automatic wave(input logic [2:0] m, input int top, input int c, input int k);
        int hi [CHANNELS] = '{default: 0};
        int ch [CHANNELS] = '{default: 0};
        int per;
        logic [CHANNELS-1:0] last;
        per = (m == WAVE_FREQ) ? 2 * (c + 1) : (m == WAVE_DUAL) ? 2 * top : top + 1;
        wr(ADDR_CONTROL_A, 16'h0000);
        wr(ADDR_CONTROL_E, 16'h0000);
        wr(ADDR_COUNTER, 16'h0000);
        wr(ADDR_CYCLE_LENGTH, 16'(top));
        for (int i = 0; i < CHANNELS; i++) wr(ADDR_MATCH_BASE + 5'(i), 16'(c));
        wr(ADDR_CONTROL_B, {9'h000, 3'h7, 1'b0, m});
        wr(ADDR_CONTROL_A, 16'h0001);
        repeat (3 * per + 4) @(negedge clock);
        last = pin_out;
        for (int j = 0; j < per * k; j++) begin
            @(posedge clock);
            port_out_value <= CHANNELS'($urandom);
            @(negedge clock);
            for (int i = 0; i < CHANNELS; i++) begin
                hi[i] += pin_out[i];
                ch[i] += (pin_out[i] != last[i]);
            end
            last = pin_out;
        end
        for (int i = 0; i < CHANNELS; i++) begin
            chk(16'(hi[i]), 16'(m == WAVE_DUAL ? 2 * k * c : k * (c + 1)), "high time");
            chk(16'(ch[i]), 16'(2 * k), "edges");
        end
    endtask

    initial begin
        v = $urandom(32'h57a8);
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(ADDR_CYCLE_LENGTH, v);
        chk(v, RESET_CYCLE_LENGTH, "reset cycle length");
        rd(ADDR_COUNTER, v);
        chk(v, RESET_ZERO, "reset counter");
        wr(ADDR_CONTROL_F, 16'h000f);
        rd(ADDR_CONTROL_F, v);
        chk(v, RESET_ZERO, "control f read only");
        rd(5'h1f, v);
        chk(v, RESET_ZERO, "unmapped read");
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            d[i] = 16'(4 + $urandom % 8);
            wr_rd(ta[i], d[i]);
        end
        rd(ADDR_CONTROL_F, v);
        chk(v, 16'h000f, "shadow valid set");
        rd(ADDR_CYCLE_LENGTH, v);
        chk(v, d[0], "length held");
        wr(ADDR_CONTROL_A, 16'h0001);
        repeat (40) @(posedge clock);
        wr(ADDR_CONTROL_A, 16'h0000);
        rd(ADDR_CONTROL_F, v);
        chk(v, 16'h0000, "shadow valid cleared");
        for (int i = 0; i < 4; i++) begin
            rd(ta[i], v);
            chk(v, d[i == 0 ? 7 : i + 3], "committed");
        end
        $display("test buffering done");
        for (int sel = 3; sel >= 0; sel--) begin
            v = 16'(3 + $urandom % 8);
            wr(ADDR_CONTROL_A, 16'h0000);
            wr(ADDR_CYCLE_LENGTH, v);
            wr(ADDR_CONTROL_E, 16'h0000);
            wr(ADDR_COUNTER, 16'h0000);
            wr(ADDR_CONTROL_A, 16'(sel * 2 + 1));
            burst(v, 0, 1 << sel);
            wr(ADDR_CONTROL_E, 16'h0001);
            burst(v, 1, 1 << sel);
        end
        wr(ADDR_CONTROL_E, 16'h0000);
        wr(ADDR_CYCLE_LENGTH, 16'h00c8);
        wr_rd(ADDR_COUNTER, 16'h0064);
        wr(ADDR_CYCLE_LENGTH, 16'h0032);
        burst(16'hffff, 0, 1);
        $display("test counting done");
        wr(ADDR_CONTROL_A, 16'h0000);
        wr(ADDR_CYCLE_LENGTH, 16'h0009);
        wr(ADDR_COUNTER, 16'h0000);
        for (int i = 0; i < CHANNELS; i++) wr(ADDR_MATCH_BASE + 5'(i), 16'(2 * i + 2));
        wr(ADDR_CONTROL_A, 16'h0001);
        repeat (12) @(negedge clock);
        chk(16'(match_irq), 16'h0000, "irq masked");
        rd(ADDR_MATCH_FLAGS, v);
        chk(v, 16'h0007, "flags set");
        wr(ADDR_MATCH_IRQ_EN, 16'h0005);
        repeat (3) @(negedge clock);
        chk(16'(match_irq), 16'h0005, "irq gated");
        wr(ADDR_CONTROL_A, 16'h0000);
        wr(ADDR_MATCH_FLAGS, 16'h0007);
        repeat (3) @(negedge clock);
        chk(16'(match_irq), 16'h0000, "irq cleared");
        $display("test flags done");
        for (int i = 0; i < 4; i++) begin
            t = (i == 0) ? 3 : 4 + $urandom % 8;
            wave(i == 0 ? WAVE_SINGLE : i == 1 ? WAVE_DUAL : WAVE_FREQ, t, i == 3 ? 0 : 1 + $urandom % (t - 1), 3);
        end
        $display("test waves done");
        wr(ADDR_CONTROL_A, 16'h0000);
        wr(ADDR_CONTROL_B, 16'h0073);
        wr(ADDR_EVENT_CONFIG, 16'h0001);
        wr(ADDR_CYCLE_LENGTH, 16'h00ff);
        wr(ADDR_COUNTER, 16'h0000);
        wr(ADDR_CONTROL_A, 16'h0001);
        repeat (5) begin
            repeat (6) @(posedge clock);
            event_in <= 1'b1;
            repeat (6) @(posedge clock);
            event_in <= 1'b0;
        end
        repeat (6) @(posedge clock);
        rd(ADDR_COUNTER, v);
        chk(v, 16'h0005, "event count");
        chk(16'(pin_out), 16'(port_out_value), "event pin pass");
        $display("test events done");
        results();
    end
endmodule

`default_nettype wire
